/* File: sdac_pkg.sv */
// Package of constants and types for the serial DAC front end
// Notes on behaviour
// - Long frame: select low over 24 falling clocks; execute on the 24th.
// - Short frame: select low over 16 falling clocks; execute on the 16th.
// - Select rising before the final falling edge clears shift register, frame invalid.
// - Aborted frame changes neither stored code nor operating mode.
// - Power-up loads zero or midscale; held until first valid complete frame.
// - Long frame mode bits sit at frame positions 17 (upper) and 16 (lower).
// - Short frame mode bits sit at frame positions 15 (upper) and 14 (lower).
// - Mode 00 is normal with amplifier driving; other values are power-down.
// - Power-down termination: 01 one kilohm, 10 hundred kilohm, 11 open.
// - Power-down shuts analog off but keeps stored code for later restore.
// - Frames arrive most significant bit first; host reverses if needed.
// - One data bit captured per falling clock edge while select is low, up to the last frame bit.
// - Long frame: six ignored bits, two mode bits, sixteen code bits.
// - Short frame: two mode bits then 14 or 12 code bits.
package sdac_pkg;
  localparam int SDAC_LONG_BITS = 24;
  localparam int SDAC_SHORT_BITS = 16;
  localparam int SDAC_LONG_MODE_LO = 16;
  localparam int SDAC_SHORT_MODE_LO = 14;
  localparam int SDAC_MODE_W = 2;
  localparam int SDAC_CNT_W = 5;
  localparam int SDAC_CODE_MAX = 16;
  localparam logic [1:0] SDAC_MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    SDAC_MODE_NORMAL = 2'b00,
    SDAC_MODE_PD_1K = 2'b01,
    SDAC_MODE_PD_100K = 2'b10,
    SDAC_MODE_PD_OPEN = 2'b11
  } sdac_mode_t;

  typedef struct packed {
    logic amp_on;
    logic term_1k;
    logic term_100k;
    logic term_open;
  } sdac_out_t;

  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } sdac_link_t;
endpackage : sdac_pkg

/* File: sdac_sync.sv */
// Two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module sdac_sync
  import sdac_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Idle value: select high, clock low, data low
  localparam logic [WIDTH-1:0] IDLE = WIDTH'(1) << (WIDTH - 1);

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= IDLE;
      sync_reg <= IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : sdac_sync
`default_nettype wire

/* File: sdac_core.sv */
// Serial DAC front end: frame shifting, abort, mode decode and power-on code
`timescale 1ns/1ps
`default_nettype none
module sdac_core
  import sdac_pkg::*;
#(
  parameter bit LONG_FRAME = 1'b1,
  parameter int CODE_W = 16,
  parameter bit MIDSCALE_RESET = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  output logic [CODE_W-1:0] dac_code,
  output logic [1:0] op_mode,
  output logic amp_on,
  output logic term_1k,
  output logic term_100k,
  output logic term_open,
  output logic frame_done,
  output logic frame_abort
);
  localparam int FRAME_BITS = LONG_FRAME ? SDAC_LONG_BITS : SDAC_SHORT_BITS;
  localparam int MODE_LO = LONG_FRAME ? SDAC_LONG_MODE_LO : SDAC_SHORT_MODE_LO;
  // Short frames put the code right after the mode bits; a 12-bit code leaves
  // the two lowest positions unused
  localparam int CODE_LO = MODE_LO - CODE_W;
  localparam logic [SDAC_CNT_W-1:0] LAST_CNT = SDAC_CNT_W'(FRAME_BITS - 1);
  localparam logic [CODE_W-1:0] CODE_RESET =
    MIDSCALE_RESET ? (CODE_W'(1) << (CODE_W - 1)) : '0;

  typedef enum logic [1:0] {
    SDAC_ST_IDLE = 2'b00,
    SDAC_ST_SHIFT = 2'b01,
    SDAC_ST_WAIT = 2'b10
  } sdac_state_t;

  sdac_link_t link_raw;
  sdac_link_t link_s;
  logic sclk_d_reg;
  logic sclk_d_next;
  logic sync_d_reg;
  logic sync_d_next;
  sdac_state_t state_reg;
  sdac_state_t state_next;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] shift_next;
  logic [SDAC_CNT_W-1:0] cnt_reg;
  logic [SDAC_CNT_W-1:0] cnt_next;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  sdac_out_t out_reg;
  sdac_out_t out_next;
  logic done_reg;
  logic done_next;
  logic abort_reg;
  logic abort_next;
  logic sclk_fall;
  logic sync_fall;
  logic [FRAME_BITS-1:0] full_word;

  assign link_raw = '{sync_n: sync_n, sclk: sclk, din: din};

  sdac_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(link_raw),
    .sync_out(link_s)
  );

  assign sclk_fall = sclk_d_reg & ~link_s.sclk;
  assign sync_fall = sync_d_reg & ~link_s.sync_n;
  // Word as it stands once the final bit is in, msb first
  assign full_word = {shift_reg[FRAME_BITS-2:0], link_s.din};

  always_comb begin
    sclk_d_next = link_s.sclk;
    sync_d_next = link_s.sync_n;
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    code_next = code_reg;
    mode_next = mode_reg;
    done_next = 1'b0;
    abort_next = 1'b0;
    unique case (state_reg)
      SDAC_ST_IDLE: begin
        // A new frame needs a falling select edge, not just select low
        if (sync_fall) begin
          state_next = SDAC_ST_SHIFT;
          shift_next = '0;
          cnt_next = '0;
        end
      end
      SDAC_ST_SHIFT: begin
        if (link_s.sync_n) begin
          state_next = SDAC_ST_IDLE;
          shift_next = '0;
          cnt_next = '0;
          abort_next = 1'b1;
        end else if (sclk_fall) begin
          shift_next = full_word;
          cnt_next = cnt_reg + SDAC_CNT_W'(1);
          if (cnt_reg == LAST_CNT) begin
            state_next = SDAC_ST_WAIT;
            code_next = full_word[CODE_LO +: CODE_W];
            mode_next = full_word[MODE_LO +: SDAC_MODE_W];
            done_next = 1'b1;
          end
        end
      end
      SDAC_ST_WAIT: begin
        // Extra clocks after execution are ignored until select rises
        if (link_s.sync_n) begin
          state_next = SDAC_ST_IDLE;
          shift_next = '0;
        end
      end
      default: begin
        state_next = SDAC_ST_IDLE;
      end
    endcase
    // Code is never touched by mode decode, so power-down keeps it
    out_next.amp_on = (mode_next == SDAC_MODE_NORMAL);
    out_next.term_1k = (mode_next == SDAC_MODE_PD_1K);
    out_next.term_100k = (mode_next == SDAC_MODE_PD_100K);
    out_next.term_open = (mode_next == SDAC_MODE_PD_OPEN);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_d_reg <= 1'b0;
      sync_d_reg <= 1'b1;
      state_reg <= SDAC_ST_IDLE;
      shift_reg <= '0;
      cnt_reg <= '0;
      code_reg <= CODE_RESET;
      mode_reg <= SDAC_MODE_RESET;
      out_reg <= '{amp_on: 1'b1, term_1k: 1'b0, term_100k: 1'b0, term_open: 1'b0};
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      sync_d_reg <= sync_d_next;
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
      mode_reg <= mode_next;
      out_reg <= out_next;
      done_reg <= done_next;
      abort_reg <= abort_next;
    end
  end

  assign dac_code = code_reg;
  assign op_mode = mode_reg;
  assign amp_on = out_reg.amp_on;
  assign term_1k = out_reg.term_1k;
  assign term_100k = out_reg.term_100k;
  assign term_open = out_reg.term_open;
  assign frame_done = done_reg;
  assign frame_abort = abort_reg;

  chk_abort_holds: assert property (@(posedge clk) disable iff (srst)
    abort_reg |-> $stable(code_reg) && $stable(mode_reg))
    else $error("aborted frame changed code or mode");

  chk_abort_clears: assert property (@(posedge clk) disable iff (srst)
    abort_reg |-> shift_reg == '0 && state_reg == SDAC_ST_IDLE)
    else $error("abort left shift register loaded");

  chk_done_count: assert property (@(posedge clk) disable iff (srst)
    done_reg |-> cnt_reg == SDAC_CNT_W'(FRAME_BITS) && state_reg == SDAC_ST_WAIT)
    else $error("frame executed at wrong edge count");

  chk_code_load: assert property (@(posedge clk) disable iff (srst)
    done_reg |-> code_reg == shift_reg[CODE_LO +: CODE_W])
    else $error("code not taken from frame");

  chk_mode_load: assert property (@(posedge clk) disable iff (srst)
    done_reg |-> mode_reg == shift_reg[MODE_LO +: SDAC_MODE_W])
    else $error("mode not taken from frame");

  chk_code_hold: assert property (@(posedge clk) disable iff (srst)
    !done_reg |-> $stable(code_reg))
    else $error("code changed without a valid frame");

  chk_amp_mode: assert property (@(posedge clk) disable iff (srst)
    ##1 (amp_on == (op_mode == 2'b00)))
    else $error("amplifier enable disagrees with mode");

  chk_term_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot({amp_on, term_1k, term_100k, term_open}))
    else $error("output termination not exclusive");

  chk_pd_keeps: assert property (@(posedge clk) disable iff (srst)
    (!amp_on && !done_reg) |-> $stable(code_reg))
    else $error("code changed in power-down");

  chk_one_bit: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SDAC_ST_SHIFT && !link_s.sync_n && !sclk_fall) |=> $stable(cnt_reg))
    else $error("bit count moved without a falling clock");
endmodule : sdac_core
`default_nettype wire

/* File: sdac_host.sv */
// Host model that writes frames over the three-wire link
`timescale 1ns/1ps
`default_nettype none
module sdac_host (
  input wire logic clk,
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Sends the top n bits of f; n below 24 cuts the frame short
  task automatic send(input logic [23:0] f, input int n);
    @(posedge clk) sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 23; i > 23 - n; i--) begin
      sclk <= 1'b1;
      din <= f[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      // Byte-wise host: pause between bytes with select still low
      if (i % 8 == 0) repeat (8) @(posedge clk);
    end
    sync_n <= 1'b1;
    // Released line must not keep showing the last bit
    din <= ~din;
    repeat (12) @(posedge clk);
  endtask : send
endmodule : sdac_host
`default_nettype wire

/* File: sdac_core_tb.sv */
// Self-checking bench for the serial DAC front end
`timescale 1ns/1ps
`default_nettype none
module sdac_core_tb
  import sdac_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sync_n, sclk, din;
  logic [15:0] dac_code;
  logic [1:0] op_mode;
  logic amp_on, term_1k, term_100k, term_open, frame_done, frame_abort;
  logic s_sync_n, s_sclk, s_din;
  logic [11:0] s_code;
  logic [1:0] s_mode;
  logic s_amp, s_1k, s_100k, s_open, s_done, s_abort;
  int fail_count = 0;
  int total_checks = 0;
  int done_cnt = 0;
  int abort_cnt = 0;
  int s_done_cnt = 0;
  int s_abort_cnt = 0;
  int cycles = 0;
  sdac_host host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
  sdac_core #(.LONG_FRAME(1'b1), .CODE_W(16), .MIDSCALE_RESET(1'b0)) dut (
    .clk(clk), .srst(srst), .sync_n(sync_n), .sclk(sclk), .din(din),
    .dac_code(dac_code), .op_mode(op_mode), .amp_on(amp_on),
    .term_1k(term_1k), .term_100k(term_100k), .term_open(term_open),
    .frame_done(frame_done), .frame_abort(frame_abort)
  );
  // Short-frame, 12-bit, midscale-reset variant on a link of its own
  sdac_host host_short (.clk(clk), .sync_n(s_sync_n), .sclk(s_sclk), .din(s_din));
  sdac_core #(.LONG_FRAME(1'b0), .CODE_W(12), .MIDSCALE_RESET(1'b1)) dut_short (
    .clk(clk), .srst(srst), .sync_n(s_sync_n), .sclk(s_sclk), .din(s_din),
    .dac_code(s_code), .op_mode(s_mode), .amp_on(s_amp),
    .term_1k(s_1k), .term_100k(s_100k), .term_open(s_open),
    .frame_done(s_done), .frame_abort(s_abort)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Ten frames and one recovery wait take about 2140 cycles; ceiling leaves margin
  // Pulses are counted mid-cycle, where the registered outputs have settled
  always @(negedge clk) begin
    cycles++;
    if (frame_done === 1'b1) done_cnt++;
    if (frame_abort === 1'b1) abort_cnt++;
    if (s_done === 1'b1) s_done_cnt++;
    if (s_abort === 1'b1) s_abort_cnt++;
    if (cycles == 6000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic expect_out(input logic [15:0] c, input logic [1:0] m);
    check(dac_code, c);
    check(op_mode, m);
    check({amp_on, term_1k, term_100k, term_open}, 4'h8 >> m);
  endtask : expect_out
  task automatic test_reset();
    expect_out(16'h0000, 2'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_modes();
    logic [15:0] codes [4];
    codes = '{16'hFFFF, 16'h0001, 16'h8000, 16'h5A5A};
    // Ignored leading bits set high so a misplaced field shows up
    for (int m = 0; m < 4; m++) begin
      host.send({6'h3F, 2'(m), codes[m]}, 24);
      expect_out(codes[m], 2'(m));
      check(done_cnt, m + 1);
      check(dac_code, codes[m]);
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_abort();
    host.send({6'h00, 2'h0, 16'h1234}, 23);
    expect_out(16'h5A5A, 2'h3);
    check(abort_cnt, 1);
    host.send(24'h000000, 0);
    check(abort_cnt, 2);
    check(done_cnt, 4);
    // Power-down keeps the code; a normal frame then takes over
    host.send({6'h00, 2'h0, 16'h1234}, 24);
    // Output recovery time after leaving power-down, 5 us at 50 MHz
    repeat (250) @(posedge clk);
    expect_out(16'h1234, 2'h0);
    check(done_cnt, 5);
    $display("test abort done");
  endtask : test_abort
  // Short frame: mode bits, 12 code bits, two ignored bits set high in the first frame
  task automatic test_short();
    check(s_code, 12'h800);
    check(s_mode, 2'h0);
    check({s_amp, s_1k, s_100k, s_open}, 4'h8);
    host_short.send({2'h2, 12'hABC, 2'h3, 8'h00}, 16);
    check(s_code, 12'hABC);
    check(s_mode, 2'h2);
    check({s_amp, s_1k, s_100k, s_open}, 4'h2);
    check(s_done_cnt, 1);
    host_short.send({2'h0, 12'h123, 2'h0, 8'h00}, 15);
    check(s_code, 12'hABC);
    check(s_mode, 2'h2);
    check(s_abort_cnt, 1);
    check(s_done_cnt, 1);
    host_short.send({2'h0, 12'h5A6, 2'h0, 8'h00}, 16);
    check(s_code, 12'h5A6);
    check({s_amp, s_1k, s_100k, s_open}, 4'h8);
    check(s_done_cnt, 2);
    $display("test short done");
  endtask : test_short
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset();
    test_modes();
    test_abort();
    test_short();
    final_report();
  end
endmodule : sdac_core_tb
`default_nettype wire
